// ===== rtl/slx_regs.svh
// Register offsets, field positions and reset values of the lane crossbar.
// Assumes it is included by bare name from the crossbar top design file.
`ifndef SLX_REGS_SVH
`define SLX_REGS_SVH

// ----------------------------------------------------------------
// Crossbar register for logical lanes 4 and 5
// ----------------------------------------------------------------
`define SLX_XBAR_4_5_OFFSET 12'h30a
`define SLX_LANE5_SRC_LSB 3
`define SLX_LANE5_SRC_MSB 5
`define SLX_LANE4_SRC_LSB 0
`define SLX_LANE4_SRC_MSB 2
`define SLX_RESERVED_LSB 6
`define SLX_RESERVED_MSB 7
`define SLX_LANE5_SRC_RESET 3'h5
`define SLX_LANE4_SRC_RESET 3'h4
`define SLX_RESERVED_RESET 2'h0
`define SLX_SYNC_STAGES 2

`endif

// ===== rtl/slx_pkg.sv
// Types shared by the lane crossbar files.
// Assumes nothing beyond the register header.
package slx_pkg;
    // Physical lane index used as a crossbar source selector
    typedef logic [2:0] slx_sel_t;
    // Pair of selectors moved across the clock crossing
    typedef struct packed {
        slx_sel_t five;
        slx_sel_t four;
    } slx_sel_pair_t;
endpackage : slx_pkg

// ===== rtl/slx_sel_if.sv
// Selector and routed lane data between the crossbar top and one lane mux.
// Assumes both ends run on the link clock.
`timescale 1ns/100ps
interface slx_sel_if #(parameter int W = 32);
    logic [2:0] sel;
    logic [W-1:0] lane;
    modport top (output sel, input lane);
    modport mux (input sel, output lane);
endinterface : slx_sel_if

// ===== rtl/slx_lane_mux.sv
// One logical lane of the crossbar: picks one of eight physical lanes.
// Assumes data and selector are already in the link clock domain.
`timescale 1ns/100ps
module slx_lane_mux
    import slx_pkg::*;
#(
    parameter int W = 32,
    parameter int N = 8
) (
    input wire logic link_clk,
    input wire logic link_resetn,
    input wire logic [N*W-1:0] phys_data,
    slx_sel_if.mux port
);
    logic [W-1:0] lane_r;
    logic [W-1:0] lane_nxt;

    // Binary index decode of the selector
    always_comb begin
        lane_nxt = phys_data[port.sel*W +: W];
    end

    // Register the routed lane every link cycle
    always_ff @(posedge link_clk) begin
        if (!link_resetn) begin
            lane_r <= '0;
        end else begin
            lane_r <= lane_nxt;
        end
    end

    assign port.lane = lane_r;

    a_mux_decode: assert property (@(posedge link_clk) disable iff (!link_resetn)
        $past(link_resetn) |-> lane_r == $past(phys_data[port.sel*W +: W]))
        else $error("lane mux output does not follow selected physical lane");
endmodule : slx_lane_mux

// ===== rtl/slx_crossbar_top.sv
// Receive lane crossbar for logical lanes 4 and 5 with its configuration register.
// Assumes a configuration port on core_clk and deserialized lane words on link_clk.
//
// Contract
// - Bits 5:3 select physical source of logical lane five, reset 5.
// - Bits 2:0 select physical source of logical lane four, reset 4.
// - Selector code is a binary index: 000 lane zero up to 111 lane seven.
// - Bits 7:6 reserved: read as zero, writes ignored.
`timescale 1ns/100ps
`include "slx_regs.svh"
module slx_crossbar_top
    import slx_pkg::*;
#(
    parameter int W = 32,
    parameter int N = 8,
    parameter int AW = 12
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [AW-1:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic [N-1:0] cfg_sel_pending,
    input wire logic link_clk,
    input wire logic [N*W-1:0] physical_serial_input,
    output logic [W-1:0] logic_lane_four,
    output logic [W-1:0] logic_lane_five
);
    // ----------------------------------------------------------------
    // Configuration register (core domain)
    // ----------------------------------------------------------------
    slx_sel_pair_t cfg_r, cfg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hit;

    assign hit = (cfg_addr == `SLX_XBAR_4_5_OFFSET);

    // Register write and read decode
    always_comb begin
        cfg_nxt = cfg_r;
        rdata_nxt = rdata_r;
        if (cfg_wr && hit) begin
            cfg_nxt.five = cfg_wdata[`SLX_LANE5_SRC_MSB:`SLX_LANE5_SRC_LSB];
            cfg_nxt.four = cfg_wdata[`SLX_LANE4_SRC_MSB:`SLX_LANE4_SRC_LSB];
        end
        if (cfg_rd) begin
            rdata_nxt = hit ? {`SLX_RESERVED_RESET, cfg_r.five, cfg_r.four} : 8'h00;
        end
    end

    // Register state, defaults restored in reset
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg_r.five <= `SLX_LANE5_SRC_RESET;
            cfg_r.four <= `SLX_LANE4_SRC_RESET;
            rdata_r <= 8'h00;
        end else begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Selector crossing: toggle handshake, core side
    // ----------------------------------------------------------------
    slx_sel_pair_t sent_r, sent_nxt;
    logic req_r, req_nxt;
    logic ack_m_r, ack_s_r;
    logic link_ack_r;
    logic pend_r, pend_nxt;

    // Launch a new selector pair only while the previous one is acknowledged
    always_comb begin
        sent_nxt = sent_r;
        req_nxt = req_r;
        if ((ack_s_r == req_r) && (cfg_r != sent_r)) begin
            sent_nxt = cfg_r;
            req_nxt = ~req_r;
        end
        pend_nxt = (ack_s_r != req_nxt) || (cfg_r != sent_nxt);
    end

    // Core side of the handshake, ack brought in through two flops
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sent_r.five <= `SLX_LANE5_SRC_RESET;
            sent_r.four <= `SLX_LANE4_SRC_RESET;
            req_r <= 1'b0;
            ack_m_r <= 1'b0;
            ack_s_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            sent_r <= sent_nxt;
            req_r <= req_nxt;
            ack_m_r <= link_ack_r;
            ack_s_r <= ack_m_r;
            pend_r <= pend_nxt;
        end
    end

    assign cfg_sel_pending = {N{pend_r}};

    // ----------------------------------------------------------------
    // Link domain: reset synchroniser and selector capture
    // ----------------------------------------------------------------
    logic lrst_m_r, lrst_s_r;
    logic req_m_r, req_s_r;
    slx_sel_pair_t sel_link_r, sel_link_nxt;
    logic link_ack_nxt;

    // Reset brought into the link domain through two flops
    always_ff @(posedge link_clk) begin
        lrst_m_r <= resetn;
        lrst_s_r <= lrst_m_r;
    end

    // Take the held pair once the request toggle has settled
    always_comb begin
        sel_link_nxt = sel_link_r;
        link_ack_nxt = link_ack_r;
        if (req_s_r != link_ack_r) begin
            sel_link_nxt = sent_r;
            link_ack_nxt = req_s_r;
        end
    end

    // Link side of the handshake, request brought in through two flops
    always_ff @(posedge link_clk) begin
        if (!lrst_s_r) begin
            req_m_r <= 1'b0;
            req_s_r <= 1'b0;
            link_ack_r <= 1'b0;
            sel_link_r.five <= `SLX_LANE5_SRC_RESET;
            sel_link_r.four <= `SLX_LANE4_SRC_RESET;
        end else begin
            req_m_r <= req_r;
            req_s_r <= req_m_r;
            link_ack_r <= link_ack_nxt;
            sel_link_r <= sel_link_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Crossbar lanes
    // ----------------------------------------------------------------
    slx_sel_if #(.W(W)) four_if ();
    slx_sel_if #(.W(W)) five_if ();

    assign four_if.sel = sel_link_r.four;
    assign five_if.sel = sel_link_r.five;

    slx_lane_mux #(.W(W), .N(N)) u_four (
        .link_clk(link_clk),
        .link_resetn(lrst_s_r),
        .phys_data(physical_serial_input),
        .port(four_if)
    );

    slx_lane_mux #(.W(W), .N(N)) u_five (
        .link_clk(link_clk),
        .link_resetn(lrst_s_r),
        .phys_data(physical_serial_input),
        .port(five_if)
    );

    assign logic_lane_four = four_if.lane;
    assign logic_lane_five = five_if.lane;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_five_reset: assert property (@(posedge core_clk)
        !resetn |=> cfg_r.five == 3'h5)
        else $error("lane five selector not 5 after reset");

    a_four_reset: assert property (@(posedge core_clk)
        !resetn |=> cfg_r.four == 3'h4)
        else $error("lane four selector not 4 after reset");

    a_write_fields: assert property (@(posedge core_clk) disable iff (!resetn)
        cfg_wr && hit |=> cfg_r == {$past(cfg_wdata[5:3]), $past(cfg_wdata[2:0])})
        else $error("selector write not stored");

    a_read_reserved: assert property (@(posedge core_clk) disable iff (!resetn)
        cfg_rd && hit |=> cfg_rdata == {2'b00, $past(cfg_r.five), $past(cfg_r.four)})
        else $error("register read wrong or reserved bits nonzero");

    a_sel_takes: assert property (@(posedge link_clk) disable iff (!lrst_s_r)
        $changed(sel_link_r) ##0 $past(lrst_s_r) |=>
        logic_lane_five == $past(physical_serial_input[sel_link_r.five*W +: W]))
        else $error("new selector not effective on next link cycle");

    // Four lane follows its new selector one link cycle later
    a_four_takes: assert property (@(posedge link_clk) disable iff (!lrst_s_r)
        $changed(sel_link_r) ##0 $past(lrst_s_r) |=>
        logic_lane_four == $past(physical_serial_input[sel_link_r.four*W +: W]))
        else $error("new lane four selector not effective on next link cycle");

    // Reads away from the register return zero
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (!resetn)
        cfg_rd && !hit |=> cfg_rdata == 8'h00)
        else $error("read of unmapped address not zero");

    // Selectors hold without a write to the register
    a_write_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        !(cfg_wr && hit) |=> $stable(cfg_r))
        else $error("selector changed without a register write");

    // Pair seen by the link stays put while a request is open
    a_sent_stable: assert property (@(posedge core_clk) disable iff (!resetn)
        (ack_s_r != req_r) |=> $stable(sent_r))
        else $error("crossing pair changed during open request");

    // Link copy of the selectors returns to the defaults in reset
    a_link_defaults: assert property (@(posedge link_clk)
        !lrst_s_r |=> sel_link_r.five == `SLX_LANE5_SRC_RESET && sel_link_r.four == `SLX_LANE4_SRC_RESET)
        else $error("link selectors not at defaults after reset");
endmodule : slx_crossbar_top

// ===== testbench/slx_lane_source.sv
// Far-side model: transmitter feeding eight deserialized lane words.
// Assumes the bench supplies a free-running link clock.
`timescale 1ns/100ps
module slx_lane_source #(
    parameter int W = 32
) (
    input wire logic link_clk,
    output logic [8*W-1:0] lanes,
    output logic [23:0] cnt_r
);
    // Running word count, stepped just after each rising link edge
    initial cnt_r = 24'h000000;
    always @(posedge link_clk) begin
        cnt_r <= cnt_r + 24'h000001;
    end
    // Lane index on top so a wrong route is visible
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            lanes[k*W +: W] = {k[7:0], cnt_r};
        end
    end
endmodule : slx_lane_source

// ===== testbench/test_serdes_lane_crossbar_4_5.sv
// Self-checking bench for the lane 4/5 crossbar and its register.
// Assumes the design under rtl/ and the lane source model.
`timescale 1ns/100ps
module test_serdes_lane_crossbar_4_5;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [11:0] cfg_addr = 12'h30a;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic [7:0] rd_v;
    logic [7:0] cfg_sel_pending;
    logic [255:0] phys;
    logic [31:0] lane4;
    logic [31:0] lane5;
    logic [23:0] cnt_r;
    // Rows: written value, expected read-back
    logic [15:0] rows [9] = '{16'h3838, 16'h3131, 16'h2a2a, 16'h2323, 16'h1c1c,
                              16'h1515, 16'h0e0e, 16'h0707, 16'hff3f};
    int err_total = 0;
    int n_tests = 0;

    // Clocks: core 5 ns, link 64 ns with its own phase
    always #2.5 core_clk = ~core_clk;
    initial #7 forever #32 link_clk = ~link_clk;

    slx_lane_source #(.W(32)) src_u (.link_clk(link_clk), .lanes(phys), .cnt_r(cnt_r));
    slx_crossbar_top #(.W(32), .N(8), .AW(12)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_sel_pending(cfg_sel_pending), .link_clk(link_clk),
        .physical_serial_input(phys), .logic_lane_four(lane4), .logic_lane_five(lane5));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One write strobe, driven on the falling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge core_clk);
        cfg_wr = 1'b0;
    endtask : wr

    // One read strobe, data taken a cycle later
    task automatic rd(input logic [11:0] a);
        @(negedge core_clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge core_clk);
        cfg_rd = 1'b0;
        @(negedge core_clk);
        rd_v = cfg_rdata;
    endtask : rd

    // Wait for the crossing, then compare both routed lanes
    task automatic lanes_chk(input logic [7:0] v);
        int i;
        i = 0;
        // One cycle so the pending flag has seen the last write
        @(negedge core_clk);
        while (cfg_sel_pending !== 8'h00 && i < 400) begin
            @(negedge core_clk);
            i++;
        end
        if (i >= 400) begin
            err_total++;
            $display("CHECK FAILED at %0t: pending stuck", $time);
        end
        repeat (4) @(posedge link_clk);
        @(negedge link_clk);
        chk(lane4, {5'h00, v[2:0], cnt_r - 24'h000001}, "lane four");
        chk(lane5, {5'h00, v[5:3], cnt_r - 24'h000001}, "lane five");
    endtask : lanes_chk

    task automatic summarize();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Hang guard
    initial begin
        #100000;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        summarize();
    end

    // Main sequence; reset held over three rising link edges so the link side sees it
    initial begin
        repeat (3) @(posedge link_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        rd(12'h30a);
        chk(rd_v, 8'h2c, "reset value");
        lanes_chk(8'h2c);
        foreach (rows[r]) begin
            wr(12'h30a, rows[r][15:8]);
            rd(12'h30a);
            chk(rd_v, rows[r][7:0], "readback");
            chk(cfg_sel_pending, 8'hff, "pending after write");
            lanes_chk(rows[r][7:0]);
        end
        // Unmapped place: write ignored, read zero
        wr(12'h30b, 8'h00);
        rd(12'h30b);
        chk(rd_v, 8'h00, "unmapped read");
        rd(12'h30a);
        chk(rd_v, 8'h3f, "after unmapped write");
        // Back-to-back writes: the last must win
        wr(12'h30a, 8'h01);
        wr(12'h30a, 8'hfe);
        lanes_chk(8'h3e);
        // Reset in mid-run restores the defaults
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (60) @(negedge core_clk);
        resetn = 1'b1;
        rd(12'h30a);
        chk(rd_v, 8'h2c, "second reset");
        lanes_chk(8'h2c);
        summarize();
    end
endmodule : test_serdes_lane_crossbar_4_5
